// ==== hw/hvprog_pkg.sv ====
// constants, carriers and states of the parallel high-voltage programming port
// assumes one 100 MHz clock; all pins arrive asynchronously and are synchronised
// Functional notes
// - load strobe rising: action 00 address, 01 data, 10 command, 11 nothing
// - first byte select picks low (0) or high (1) byte on loads
// - second byte select picks the second high byte on fuse writes, and on fuse reads when first select is low
// - write commands: 80 erase, 40 fuses, 20 lock, 10 flash, 11 eeprom
// - read commands: 08 signature, 04 fuses and lock, 02 flash, 03 eeprom
// - ready/busy low while an operation runs, high when ready
// - data bus driven only while output enable is low
// - programming mode ends when reset high voltage is removed
// - loaded command and address are retained across operations
// - chip erase clears flash, eeprom, lock; lock clears after flash done
// - eeprom-preserve fuse programmed keeps eeprom through chip erase
// - write strobe low pulse starts operation and pulls ready/busy low
// - page latch rising with first select high stores data word in buffer
// - low address bits pick word in page, upper bits pick page
// - flash write command plus write strobe programs the whole page
// - page buffer holds 32 or 64 words, set by PAGE_WORDS independently of memory size
// - fuses latched on entry; preserve fuse acts as soon as programmed

package hvprog_pkg;
	typedef logic [7:0] byte_t;

	// action codes on the load strobe
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD  = 2'h2;

	// command bytes
	localparam byte_t CMD_ERASE      = 8'h80;
	localparam byte_t CMD_WR_FUSE    = 8'h40;
	localparam byte_t CMD_WR_LOCK    = 8'h20;
	localparam byte_t CMD_WR_FLASH   = 8'h10;
	localparam byte_t CMD_WR_EEPROM  = 8'h11;
	localparam byte_t CMD_RD_SIG     = 8'h08;
	localparam byte_t CMD_RD_FUSE    = 8'h04;
	localparam byte_t CMD_RD_FLASH   = 8'h02;
	localparam byte_t CMD_RD_EEPROM  = 8'h03;

	// reset values and field positions
	localparam byte_t ERASED_BYTE    = 8'hFF;
	localparam byte_t LOCK_RESET     = 8'hFF;
	localparam byte_t FUSE_LOW_RESET = 8'h62;
	localparam byte_t FUSE_HIGH_RESET = 8'hDF;
	localparam byte_t FUSE_EXT_RESET = 8'hF9;
	localparam int    EEPROM_PRESERVE_FUSE_BIT     = 3;
	localparam int    CNT_W          = 16;

	// fuse bytes as a group
	typedef struct packed {
		byte_t ext;
		byte_t high;
		byte_t low;
	} fuse_t;

	// programming pins after synchronisation
	typedef struct packed {
		logic       hv;
		logic       page_latch_strobe;
		logic [1:0] action_code;
		logic       byte_select_first;
		logic       byte_select_second;
		logic       wr_n;
		logic       oe_n;
		logic       load_strobe;
		byte_t      data;
	} pin_t;

	typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_FLASH_PROG, ST_EE_PROG, ST_SHORT} op_t;
endpackage

// ==== hw/pin_sync.sv ====
// two-flop synchroniser for a group of asynchronous pins
// assumes the consumer reads only the sync_out vector
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 8
) (
	input  wire logic         CLK,
	input  wire logic         RESET_N,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta;

	// one pair of flops per bit
	generate
		for (genvar i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge CLK or negedge RESET_N) begin
				if (!RESET_N) begin
					meta[i]     <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					meta[i]     <= async_in[i];
					sync_out[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule

// ==== hw/hvprog_port.sv ====
// parallel programming port: loads, page buffer, flash/eeprom/fuse/lock storage
// assumes pins come straight from pads; high voltage detect is a level input
`timescale 1ns/1ps
module hvprog_port #(
	parameter int FLASH_WORDS     = 8192,
	parameter int PAGE_WORDS      = 64,
	parameter int EE_BYTES        = 512,
	parameter int EE_PAGE         = 4,
	parameter int OP_SHORT_CYCLES = 16,
	parameter logic [7:0] SIG0    = 8'h5A, // arbitrary
	parameter logic [7:0] SIG1    = 8'h3C, // arbitrary
	parameter logic [7:0] SIG2    = 8'h11, // arbitrary
	parameter logic [7:0] CAL     = 8'h80  // arbitrary
) (
	input  wire logic              CLK,
	input  wire logic              RESET_N,
	input  wire logic              HV_RESET_ACTIVE,
	input  wire logic              LOAD_STROBE,
	input  wire logic              ACTION_CODE_BIT0,
	input  wire logic              ACTION_CODE_BIT1,
	input  wire logic              BYTE_SELECT_FIRST,
	input  wire logic              BYTE_SELECT_SECOND,
	input  wire logic              PAGE_LATCH_STROBE,
	input  wire logic              WRITE_STROBE_N,
	input  wire logic              OUTPUT_ENABLE_N,
	input  wire hvprog_pkg::byte_t DATA_IN,
	output hvprog_pkg::byte_t      DATA_OUT,
	output logic                   DATA_OE,
	output logic                   READY_BUSY_N,
	output logic                   PROG_MODE,
	output hvprog_pkg::fuse_t      ACTIVE_FUSES
);
	import hvprog_pkg::*;

	localparam int FA_W = $clog2(FLASH_WORDS);
	localparam int PW_W = $clog2(PAGE_WORDS);
	localparam int EA_W = $clog2(EE_BYTES);
	localparam int EP_W = $clog2(EE_PAGE);
	localparam logic [CNT_W-1:0] FL_LAST = CNT_W'(FLASH_WORDS - 1);
	localparam logic [CNT_W-1:0] PG_LAST = CNT_W'(PAGE_WORDS - 1);
	localparam logic [CNT_W-1:0] EP_LAST = CNT_W'(EE_PAGE - 1);
	localparam logic [CNT_W-1:0] SH_LAST = CNT_W'(OP_SHORT_CYCLES - 1);
	localparam logic [CNT_W-1:0] EE_TOP  = CNT_W'(EE_BYTES);

	initial begin
		if (PAGE_WORDS != 32 && PAGE_WORDS != 64)
			$error("PAGE_WORDS must be 32 or 64");
		if (FLASH_WORDS > 65536 || FLASH_WORDS < EE_BYTES || EE_BYTES > 65536)
			$error("memory sizes out of range");
		if (EE_PAGE < 2 || EE_PAGE > 256 || OP_SHORT_CYCLES < 1)
			$error("bad page or timing parameter");
	end

	typedef struct packed {
		logic             in_prog;
		logic             ready;
		op_t              op;
		logic [CNT_W-1:0] cnt;
		byte_t            cmd;
		byte_t            addr_lo;
		byte_t            addr_hi;
		byte_t            data_lo;
		byte_t            data_hi;
		byte_t            lock;
		fuse_t            fuse;
		fuse_t            fuse_act;
		byte_t            dout;
		logic             dout_oe;
		pin_t             prev;
	} state_t;

	state_t r;
	state_t next_r;
	pin_t   s;

	logic [15:0] flash [FLASH_WORDS];
	byte_t       eeprom [EE_BYTES];
	logic [15:0] page_buf [PAGE_WORDS];
	byte_t       ee_buf [EE_PAGE];

	logic            flash_we;
	logic [FA_W-1:0] flash_wa;
	logic [15:0]     flash_wd;
	logic            ee_we;
	logic [EA_W-1:0] ee_wa;
	byte_t           ee_wd;
	logic            buf_we;
	logic [15:0]     buf_wd;
	logic            eebuf_we;
	logic [15:0]     addr;
	logic            load_rise;
	logic            latch_rise;
	logic            wr_fall;
	logic            ee_keep;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisation
	pin_sync #(.W($bits(pin_t))) u_sync (
		.CLK      (CLK),
		.RESET_N  (RESET_N),
		.async_in ({HV_RESET_ACTIVE, PAGE_LATCH_STROBE, ACTION_CODE_BIT1, ACTION_CODE_BIT0,
		            BYTE_SELECT_FIRST, BYTE_SELECT_SECOND, WRITE_STROBE_N, OUTPUT_ENABLE_N,
		            LOAD_STROBE, DATA_IN}),
		.sync_out (s)
	);

	// edges of the strobes, only inside programming mode
	assign load_rise  = r.in_prog && s.load_strobe && !r.prev.load_strobe;
	assign latch_rise = r.in_prog && s.page_latch_strobe && !r.prev.page_latch_strobe;
	assign wr_fall    = r.in_prog && !s.wr_n && r.prev.wr_n;
	assign addr       = {r.addr_hi, r.addr_lo};
	// preserve fuse acts from its live value
	assign ee_keep    = !r.fuse.high[EEPROM_PRESERVE_FUSE_BIT];

	////////////////////////////////////////////////////////////////////////
	// control and state update
	always_comb begin
		next_r       = r;
		next_r.prev  = s;
		flash_we     = 1'b0;
		flash_wa     = addr[FA_W-1:0];
		flash_wd     = 16'hFFFF;
		ee_we        = 1'b0;
		ee_wa        = addr[EA_W-1:0];
		ee_wd        = ERASED_BYTE;
		buf_we       = 1'b0;
		buf_wd       = {r.data_hi, r.data_lo};
		eebuf_we     = 1'b0;
		// entry with pattern 0000 when high voltage appears
		if (s.hv && !r.prev.hv && !r.in_prog &&
		    {s.page_latch_strobe, s.action_code, s.byte_select_first} == 4'h0) begin
			next_r.in_prog  = 1'b1;
			next_r.fuse_act = r.fuse;
		end
		// leave mode when high voltage drops
		if (!s.hv) begin
			next_r.in_prog = 1'b0;
			next_r.op      = ST_IDLE;
		end
		// capture bus on load strobe edge
		if (load_rise) begin
			unique case (s.action_code)
				ACT_ADDR: if (s.byte_select_first) next_r.addr_hi = s.data;
				          else next_r.addr_lo = s.data;
				ACT_DATA: if (s.byte_select_first) next_r.data_hi = s.data;
				          else next_r.data_lo = s.data;
				ACT_CMD:  next_r.cmd = s.data;
				default:  ;
			endcase
		end
		// latch data word into page buffer
		if (latch_rise) begin
			if (r.cmd == CMD_WR_EEPROM)
				eebuf_we = 1'b1;
			else if (s.byte_select_first)
				buf_we = 1'b1;
		end
		// write strobe starts the loaded operation
		if (wr_fall && r.op == ST_IDLE) begin
			next_r.cnt = '0;
			unique case (r.cmd)
				CMD_ERASE:     next_r.op = ST_ERASE;
				CMD_WR_FLASH:  next_r.op = ST_FLASH_PROG;
				CMD_WR_EEPROM: next_r.op = ST_EE_PROG;
				CMD_WR_LOCK: begin
					next_r.lock = r.lock & r.data_lo;
					next_r.op   = ST_SHORT;
				end
				CMD_WR_FUSE: begin
					next_r.op = ST_SHORT;
					if (s.byte_select_second)
						next_r.fuse.ext = r.data_lo;
					else if (s.byte_select_first)
						next_r.fuse.high = r.data_lo;
					else
						next_r.fuse.low = r.data_lo;
				end
				default:       next_r.op = ST_IDLE;
			endcase
		end
		// running operations: erase and page programs step one location per cycle, short ops only count
		unique case (r.op)
			ST_IDLE: ;
			ST_ERASE: begin
				flash_we = 1'b1;
				flash_wa = r.cnt[FA_W-1:0];
				ee_wa    = r.cnt[EA_W-1:0];
				// eeprom kept when preserve fuse programmed
				ee_we    = !ee_keep && r.cnt < EE_TOP;
				next_r.cnt = r.cnt + 1'b1;
				if (r.cnt == FL_LAST) begin
					next_r.lock = LOCK_RESET;
					next_r.op   = ST_IDLE;
				end
			end
			ST_FLASH_PROG: begin
				// page from upper bits, word from counter
				flash_we = 1'b1;
				flash_wa = {addr[FA_W-1:PW_W], r.cnt[PW_W-1:0]};
				flash_wd = page_buf[r.cnt[PW_W-1:0]];
				next_r.cnt = r.cnt + 1'b1;
				if (r.cnt == PG_LAST)
					next_r.op = ST_IDLE;
			end
			ST_EE_PROG: begin
				ee_we = 1'b1;
				ee_wa = {addr[EA_W-1:EP_W], r.cnt[EP_W-1:0]};
				ee_wd = ee_buf[r.cnt[EP_W-1:0]];
				next_r.cnt = r.cnt + 1'b1;
				if (r.cnt == EP_LAST)
					next_r.op = ST_IDLE;
			end
			ST_SHORT: begin
				next_r.cnt = r.cnt + 1'b1;
				if (r.cnt == SH_LAST)
					next_r.op = ST_IDLE;
			end
			default: next_r.op = ST_IDLE;
		endcase
		// ready only when no operation runs
		next_r.ready = next_r.op == ST_IDLE;
		// drive bus only while output enable low
		next_r.dout_oe = r.in_prog && !s.oe_n;
		unique case (r.cmd)
			CMD_RD_FLASH:  next_r.dout = s.byte_select_first ? flash[addr[FA_W-1:0]][15:8]
			                                                 : flash[addr[FA_W-1:0]][7:0];
			CMD_RD_EEPROM: next_r.dout = eeprom[addr[EA_W-1:0]];
			CMD_RD_FUSE: begin
				unique case ({s.byte_select_second, s.byte_select_first})
					2'h0:    next_r.dout = r.fuse.low;
					2'h3:    next_r.dout = r.fuse.high;
					2'h2:    next_r.dout = r.fuse.ext;
					default: next_r.dout = r.lock;
				endcase
			end
			CMD_RD_SIG: begin
				if (s.byte_select_first)
					next_r.dout = CAL;
				else if (r.addr_lo[1:0] == 2'h0)
					next_r.dout = SIG0;
				else if (r.addr_lo[1:0] == 2'h1)
					next_r.dout = SIG1;
				else
					next_r.dout = SIG2;
			end
			default:       next_r.dout = 8'h00;
		endcase
	end

	// state register
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			r          <= '0;
			r.ready    <= 1'b1;
			r.op       <= ST_IDLE;
			r.lock     <= LOCK_RESET;
			r.fuse     <= '{ext: FUSE_EXT_RESET, high: FUSE_HIGH_RESET, low: FUSE_LOW_RESET};
			r.fuse_act <= '{ext: FUSE_EXT_RESET, high: FUSE_HIGH_RESET, low: FUSE_LOW_RESET};
			r.prev.wr_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// nonvolatile arrays and page buffers, no reset
	always_ff @(posedge CLK) begin
		if (flash_we)
			flash[flash_wa] <= flash_wd;
		if (ee_we)
			eeprom[ee_wa] <= ee_wd;
		if (buf_we)
			page_buf[addr[PW_W-1:0]] <= buf_wd;
		if (eebuf_we)
			ee_buf[addr[EP_W-1:0]] <= r.data_lo;
	end

	assign DATA_OUT     = r.dout;
	assign DATA_OE      = r.dout_oe;
	assign READY_BUSY_N = r.ready;
	assign PROG_MODE    = r.in_prog;
	assign ACTIVE_FUSES = r.fuse_act;

	////////////////////////////////////////////////////////////////////////
	// checks
	AST_ERASE_BUSY: assert property (@(posedge CLK) disable iff (!RESET_N)
		wr_fall && r.ready && r.cmd == CMD_ERASE |=> !READY_BUSY_N ##1 !READY_BUSY_N)
		else $error("erase did not pull ready low");
	AST_BUS_DRIVE: assert property (@(posedge CLK) disable iff (!RESET_N)
		DATA_OE |-> !$past(s.oe_n) && $past(r.in_prog))
		else $error("bus driven without output enable");
	AST_CMD_LOAD: assert property (@(posedge CLK) disable iff (!RESET_N)
		load_rise && s.action_code == ACT_CMD |=> r.cmd == $past(s.data))
		else $error("command byte not captured");
	AST_ADDR_HIGH: assert property (@(posedge CLK) disable iff (!RESET_N)
		load_rise && s.action_code == ACT_ADDR && s.byte_select_first
		|=> r.addr_hi == $past(s.data) && $stable(r.addr_lo))
		else $error("address high byte load wrong");
	AST_CMD_KEPT: assert property (@(posedge CLK) disable iff (!RESET_N)
		!(load_rise && s.action_code == ACT_CMD) |=> $stable(r.cmd))
		else $error("command changed without load");
	AST_LOCK_LATE: assert property (@(posedge CLK) disable iff (!RESET_N)
		r.op == ST_ERASE && r.cnt != FL_LAST && s.hv |=> $stable(r.lock) && !READY_BUSY_N)
		else $error("lock changed before flash erased");
	AST_PAGE_END: assert property (@(posedge CLK) disable iff (!RESET_N)
		r.op == ST_FLASH_PROG && r.cnt == PG_LAST |-> flash_we ##1 READY_BUSY_N)
		else $error("page program did not finish");
	AST_FUSE_HELD: assert property (@(posedge CLK) disable iff (!RESET_N)
		r.in_prog |=> $stable(r.fuse_act))
		else $error("active fuses changed in programming mode");
	AST_EE_KEEP: assert property (@(posedge CLK) disable iff (!RESET_N)
		r.op == ST_ERASE && ee_keep |-> !ee_we)
		else $error("eeprom erased while preserved");
	AST_LATCH_WORD: assert property (@(posedge CLK) disable iff (!RESET_N)
		latch_rise && s.byte_select_first && r.cmd != CMD_WR_EEPROM
		|-> buf_we && buf_wd == {r.data_hi, r.data_lo})
		else $error("page latch did not store word");
endmodule

// ==== tb/hv_programmer.sv ====
// behavioural parallel programmer driving the port pins
// assumes the bench resolves the data bus from drv and the device enable
`timescale 1ns/1ps
module hv_programmer (
	input  wire logic              CLK,
	input  wire logic              ready_busy_n,
	input  wire hvprog_pkg::byte_t bus,
	output logic                   hv,
	output logic                   load_strobe,
	output logic [1:0]             action_code,
	output logic                   byte_select_first,
	output logic                   byte_select_second,
	output logic                   page_latch_strobe,
	output logic                   wr_n,
	output logic                   oe_n,
	output hvprog_pkg::byte_t      dat,
	output logic                   drv
);
	import hvprog_pkg::*;
	localparam int PW = 26;

	////////////////////////////////////////////////////////////
	// idle pins, entry pattern already in place
	initial begin
		{hv, load_strobe, action_code, byte_select_first, byte_select_second, page_latch_strobe} = 7'h00;
		{wr_n, oe_n, drv} = 3'h7;
		dat = 8'h00;
	end

	// one strobe with setup and recovery around it
	task automatic pulse(input bit pg);
		repeat (PW) @(negedge CLK);
		if (pg) begin
			page_latch_strobe = 1'b1;
		end else begin
			load_strobe = 1'b1;
		end
		repeat (PW) @(negedge CLK);
		{page_latch_strobe, load_strobe} = 2'h0;
		repeat (PW) @(negedge CLK);
	endtask

	// action, select and byte, then load
	task automatic load(input logic [1:0] a, input logic b1, input byte_t d);
		@(negedge CLK);
		{action_code, byte_select_first, byte_select_second, dat} = {a, b1, 1'b0, d};
		pulse(1'b0);
	endtask

	task automatic latch(input logic b1);
		@(negedge CLK);
		byte_select_first = b1;
		pulse(1'b1);
	endtask

	// write pulse, bounded wait for ready
	task automatic wr(input logic b1, input logic b2, output int busy, output bit ok);
		busy = 0;
		ok = 1'b0;
		@(negedge CLK);
		{byte_select_first, byte_select_second} = {b1, b2};
		wr_n = 1'b0;
		for (int i = 0; i < 3000 && !ok; i++) begin
			@(negedge CLK);
			if (i == PW) wr_n = 1'b1;
			if (ready_busy_n === 1'b0) busy++;
			else if (busy > 0 && i > PW) ok = 1'b1;
		end
		byte_select_second = 1'b0;
	endtask

	// bus released, output enable low, sample, restore
	task automatic rd(input logic b1, input logic b2, output byte_t d);
		@(negedge CLK);
		{byte_select_first, byte_select_second, drv} = {b1, b2, 1'b0};
		oe_n = 1'b0;
		repeat (PW) @(negedge CLK);
		d = bus;
		oe_n = 1'b1;
		repeat (PW) @(negedge CLK);
		{drv, byte_select_second} = 2'b10;
	endtask

	task automatic enter();
		@(negedge CLK);
		hv = 1'b1;
		repeat (30100) @(negedge CLK);
	endtask

	task automatic leave();
		@(negedge CLK);
		hv = 1'b0;
	endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the parallel programming port
// assumes hv_programmer as far side and shortened counts
`timescale 1ns/1ps
module tb;
	import hvprog_pkg::*;
	localparam int    FW  = 256;
	localparam int    PG  = 32;
	localparam int    SH  = 16;
	localparam byte_t SG1 = 8'hB2; // arbitrary
	localparam byte_t CL  = 8'h47; // arbitrary
	logic       CLK     = 1'b0;
	logic       RESET_N = 1'b0;
	logic       hv, ls, lp, sf, ss, wn, on, drv, oe, rdy, pm;
	logic [1:0] act;
	byte_t      dat, dout, bus;
	fuse_t      fuses;
	int         error_cnt = 0;
	int         checked   = 0;

	always #5 CLK = ~CLK;
	// released bus shows the inverse of the last value
	assign bus = oe ? dout : (drv ? dat : ~dat);

	hv_programmer i_prog (.CLK(CLK), .ready_busy_n(rdy), .bus(bus), .hv(hv), .load_strobe(ls),
		.action_code(act), .byte_select_first(sf), .byte_select_second(ss), .page_latch_strobe(lp),
		.wr_n(wn), .oe_n(on), .dat(dat), .drv(drv));
	hvprog_port #(.FLASH_WORDS(FW), .PAGE_WORDS(PG), .EE_BYTES(64), .EE_PAGE(4), .OP_SHORT_CYCLES(SH),
		.SIG1(SG1), .CAL(CL)) i_dut (.CLK(CLK), .RESET_N(RESET_N),
		.HV_RESET_ACTIVE(hv), .LOAD_STROBE(ls), .ACTION_CODE_BIT0(act[0]), .ACTION_CODE_BIT1(act[1]),
		.BYTE_SELECT_FIRST(sf), .BYTE_SELECT_SECOND(ss), .PAGE_LATCH_STROBE(lp), .WRITE_STROBE_N(wn),
		.OUTPUT_ENABLE_N(on), .DATA_IN(bus), .DATA_OUT(dout), .DATA_OE(oe), .READY_BUSY_N(rdy),
		.PROG_MODE(pm), .ACTIVE_FUSES(fuses));

	////////////////////////////////////////////////////////////
	// compare helpers
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic ld(input logic [1:0] a, input logic b, input byte_t d);
		i_prog.load(a, b, d);
	endtask
	task automatic rdc(input string n, input logic b1, input logic b2, input byte_t e);
		byte_t d;
		i_prog.rd(b1, b2, d);
		chk(n, {16'h0, e}, {16'h0, d});
		chk("bus enable idle", 24'h0, {23'h0, oe});
	endtask
	task automatic wrc(input string n, input logic b1, input logic b2, input int len);
		int busy;
		bit ok;
		i_prog.wr(b1, b2, busy, ok);
		chk(n, 24'h1, {23'h0, ok && busy >= len - 4 && busy <= len + 4});
	endtask

	////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_entry();
		chk("mode before", 24'h0, {23'h0, pm});
		i_prog.enter();
		chk("mode entered", 24'h1, {23'h0, pm});
		chk("ready", 24'h1, {23'h0, rdy});
		chk("fuses", {FUSE_EXT_RESET, FUSE_HIGH_RESET, FUSE_LOW_RESET}, fuses);
		$display("test entry done");
	endtask
	task automatic t_erase(input byte_t ee, input byte_t fh);
		ld(ACT_CMD, 0, CMD_ERASE);
		wrc("erase busy", 0, 0, FW);
		ld(ACT_CMD, 0, CMD_RD_FLASH);
		ld(ACT_ADDR, 1, 8'h00);
		ld(ACT_ADDR, 0, 8'h00);
		rdc("flash lo", 0, 0, ERASED_BYTE);
		rdc("flash hi", 1, 0, ERASED_BYTE);
		ld(ACT_CMD, 0, CMD_RD_EEPROM);
		rdc("eeprom", 0, 0, ee);
		ld(ACT_CMD, 0, CMD_RD_FUSE);
		rdc("lock", 1, 0, LOCK_RESET);
		rdc("fuse high", 1, 1, fh);
		$display("test erase done");
	endtask
	task automatic t_flash();
		byte_t       wa[2] = '{8'h00, 8'h1F};
		logic [15:0] wd[2] = '{16'h1234, 16'hABCD};
		ld(ACT_CMD, 0, CMD_WR_FLASH);
		for (int i = 0; i < 2; i++) begin
			ld(ACT_ADDR, 0, wa[i]);
			ld(ACT_DATA, 0, wd[i][7:0]);
			ld(ACT_DATA, 1, wd[i][15:8]);
			i_prog.latch(1'b1);
		end
		ld(ACT_ADDR, 1, 8'h00);
		wrc("page busy", 1, 0, PG);
		ld(ACT_CMD, 0, CMD_RD_FLASH);
		for (int i = 0; i < 2; i++) begin
			ld(ACT_ADDR, 0, wa[i]);
			ld(2'h3, 0, 8'h00);
			rdc("word lo", 0, 0, wd[i][7:0]);
			rdc("word hi", 1, 0, wd[i][15:8]);
		end
		$display("test flash done");
	endtask
	task automatic t_fuse();
		logic [1:0] ws[3] = '{2'b10, 2'b01, 2'b00};
		logic [1:0] rs[3] = '{2'b11, 2'b01, 2'b00};
		byte_t      fv[3] = '{8'hF7, 8'hFD, 8'hE2};
		ld(ACT_CMD, 0, CMD_WR_FUSE);
		for (int i = 0; i < 3; i++) begin
			ld(ACT_DATA, 0, fv[i]);
			wrc("fuse busy", ws[i][1], ws[i][0], SH);
		end
		ld(ACT_CMD, 0, CMD_WR_LOCK);
		ld(ACT_DATA, 0, 8'hFC);
		wrc("lock busy", 0, 0, SH);
		ld(ACT_CMD, 0, CMD_RD_FUSE);
		for (int i = 0; i < 3; i++) begin
			rdc("fuse", rs[i][1], rs[i][0], fv[i]);
		end
		rdc("lock", 1, 0, 8'hFC);
		chk("fuses held", {FUSE_EXT_RESET, FUSE_HIGH_RESET, FUSE_LOW_RESET}, fuses);
		$display("test fuse done");
	endtask
	task automatic t_ee();
		ld(ACT_CMD, 0, CMD_WR_EEPROM);
		ld(ACT_ADDR, 1, 8'h00);
		ld(ACT_ADDR, 0, 8'h00);
		ld(ACT_DATA, 0, 8'h5A);
		i_prog.latch(1'b0);
		wrc("eeprom busy", 0, 0, 4);
		ld(ACT_CMD, 0, CMD_RD_EEPROM);
		rdc("eeprom", 0, 0, 8'h5A);
		$display("test eeprom done");
	endtask
	task automatic t_sig();
		ld(ACT_CMD, 0, CMD_RD_SIG);
		ld(ACT_ADDR, 0, 8'h00);
		rdc("calibration", 1, 0, CL);
		ld(ACT_ADDR, 0, 8'h01);
		rdc("signature", 0, 0, SG1);
		$display("test signature done");
	endtask
	task automatic t_exit();
		i_prog.leave();
		for (int i = 0; i < 20 && pm !== 1'b0; i++) @(negedge CLK);
		chk("mode left", 24'h0, {23'h0, pm});
		i_prog.enter();
		chk("fuses relatched", {8'hFD, 8'hF7, 8'hE2}, fuses);
		$display("test exit done");
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (16) @(negedge CLK);
		RESET_N = 1'b1;
		repeat (4) @(negedge CLK);
		t_entry();
		t_erase(8'hFF, FUSE_HIGH_RESET);
		t_flash();
		t_fuse();
		t_ee();
		t_erase(8'h5A, 8'hF7);
		t_sig();
		t_exit();
		stop_test();
	end
endmodule
